// [asi_interrupt_logic.sv]
// top of the interrupt status, masking and trigger-mode logic of the rate converter
// assumes the control-port front end turns host transfers into byte read/write strobes
// on clk_in, and that every event source is produced by logic on clk_in
//
// How it works
// - a status bit reads 1 if its condition fired since the last status read, else 0.
// - reading a status register clears it, except bits that trigger in the same cycle, such as level-mode bits whose source is still true.
// - a status bit whose mask bit is 0 reads 0, except for one cycle right after the mask bit clears.
// - the second status register is read-only, resets to zero, bits 7:6 read 0, 5:0 hold flags.
// - the second mask register has one bit per second-group event at the flag's position.
// - the first mask register has one bit per first-group event at the flag's position.
// - an unmasked event sets its status bit and drives the pin; a masked one does neither.
// - mask registers reset to zero so every event starts masked.
// - each first-group event takes its mode code upper bit and lower bit from two registers.
// - code 00 fires on arrival, 01 on removal, 10 while present, 11 is reserved.
// - all mode registers reset to zero, selecting rising-edge triggering.
// - the converter tracking event is raised while the converter follows a rate change.
// - the two user-data transfer events are true during the D-to-E and E-to-F transfers.
// - second-group events use two mode registers with the same code as the first group.
`timescale 1ns/1ps
`default_nettype none
module asi_interrupt_logic (
   input wire logic clk_in,
   input wire logic resetn_in,
   // register port
   input wire logic [asi_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [asi_pkg::DATA_W-1:0] reg_wdata_in,
   output logic [asi_pkg::DATA_W-1:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // first-group sources
   input wire logic timing_slip_event_in,
   input wire logic output_slip_event_in,
   input wire logic rate_ratio_exceeded_in,
   input wire logic left_overrange_in,
   input wire logic right_overrange_in,
   input wire logic cstat_d_to_e_transfer_in,
   input wire logic cstat_e_to_f_transfer_in,
   input wire logic receiver_fault_event_in,
   // second-group sources
   input wire logic converter_buffer_overflow_in,
   input wire logic converter_tracking_event_in,
   input wire logic user_d_to_e_transfer_in,
   input wire logic user_e_to_f_transfer_in,
   input wire logic subcode_q_ready_in,
   input wire logic user_fifo_overwrite_in,
   // interrupt pin, active high here; pin polarity is handled outside
   output logic irq_out
);
   localparam int DW = asi_pkg::DATA_W;
   localparam int W1 = asi_pkg::G1_W;
   localparam int W2 = asi_pkg::G2_W;

   logic [W1-1:0] src_g1;
   logic [W2-1:0] src_g2;
   logic [W1-1:0] mask_g1;
   logic [W1-1:0] upper_g1;
   logic [W1-1:0] lower_g1;
   logic [W1-1:0] status_g1;
   logic [W2-1:0] mask_g2;
   logic [W2-1:0] upper_g2;
   logic [W2-1:0] lower_g2;
   logic [W2-1:0] status_g2;
   logic [DW-1:0] rdata_nxt;
   logic [DW-1:0] rdata_r;
   logic rvalid_r;
   logic irq_r;
   logic irq_nxt;

   // qualified register strobes, one per target register
   logic wr_mask_g1;
   logic wr_upper_g1;
   logic wr_lower_g1;
   logic wr_mask_g2;
   logic wr_upper_g2;
   logic wr_lower_g2;
   logic rd_status_g1;
   logic rd_status_g2;

   function automatic logic hit(input logic [asi_pkg::ADDR_W-1:0] addr,
                                input logic [asi_pkg::ADDR_W-1:0] off);
      hit = (addr == off);
   endfunction

   function automatic logic [DW-1:0] widen2(input logic [W2-1:0] v);
      widen2 = {{(DW-W2){1'b0}}, v};
   endfunction

   // sources sit at the positions of their flags
   always_comb begin
      src_g1 = '0;
      src_g1[asi_pkg::BIT_TIMING_SLIP] = timing_slip_event_in;
      src_g1[asi_pkg::BIT_OUTPUT_SLIP] = output_slip_event_in;
      src_g1[asi_pkg::BIT_RATE_RATIO] = rate_ratio_exceeded_in;
      src_g1[asi_pkg::BIT_LEFT_OVR] = left_overrange_in;
      src_g1[asi_pkg::BIT_RIGHT_OVR] = right_overrange_in;
      src_g1[asi_pkg::BIT_CSTAT_DE] = cstat_d_to_e_transfer_in;
      src_g1[asi_pkg::BIT_CSTAT_EF] = cstat_e_to_f_transfer_in;
      src_g1[asi_pkg::BIT_RX_FAULT] = receiver_fault_event_in;
   end

   always_comb begin
      src_g2 = '0;
      src_g2[asi_pkg::BIT_CONV_OVF] = converter_buffer_overflow_in;
      src_g2[asi_pkg::BIT_CONV_TRACK] = converter_tracking_event_in;
      src_g2[asi_pkg::BIT_USER_DE] = user_d_to_e_transfer_in;
      src_g2[asi_pkg::BIT_USER_EF] = user_e_to_f_transfer_in;
      src_g2[asi_pkg::BIT_SUBCODE_Q] = subcode_q_ready_in;
      src_g2[asi_pkg::BIT_USER_OVW] = user_fifo_overwrite_in;
   end

   // strobes are qualified once here; writes to the status offsets
   // and to unmapped offsets decode to nothing, so they are ignored
   always_comb begin
      wr_mask_g1 = reg_wr_in && hit(reg_addr_in, asi_pkg::OFF_MASK_G1);
      wr_upper_g1 = reg_wr_in && hit(reg_addr_in, asi_pkg::OFF_MODE_G1_UPPER);
      wr_lower_g1 = reg_wr_in && hit(reg_addr_in, asi_pkg::OFF_MODE_G1_LOWER);
      wr_mask_g2 = reg_wr_in && hit(reg_addr_in, asi_pkg::OFF_MASK_G2);
      wr_upper_g2 = reg_wr_in && hit(reg_addr_in, asi_pkg::OFF_MODE_G2_UPPER);
      wr_lower_g2 = reg_wr_in && hit(reg_addr_in, asi_pkg::OFF_MODE_G2_LOWER);
      rd_status_g1 = reg_rd_in && hit(reg_addr_in, asi_pkg::OFF_STATUS_G1);
      rd_status_g2 = reg_rd_in && hit(reg_addr_in, asi_pkg::OFF_STATUS_G2);
   end

   asi_event_group #(
      .W(W1)
   ) u_group_one (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .src_in(src_g1),
      .wdata_in(reg_wdata_in[W1-1:0]),
      .mask_wr_in(wr_mask_g1),
      .upper_wr_in(wr_upper_g1),
      .lower_wr_in(wr_lower_g1),
      .status_rd_in(rd_status_g1),
      .mask_out(mask_g1),
      .upper_out(upper_g1),
      .lower_out(lower_g1),
      .status_out(status_g1)
   );

   // only the low six data bits reach the second group; bits 7:6 are not stored
   asi_event_group #(
      .W(W2)
   ) u_group_two (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .src_in(src_g2),
      .wdata_in(reg_wdata_in[W2-1:0]),
      .mask_wr_in(wr_mask_g2),
      .upper_wr_in(wr_upper_g2),
      .lower_wr_in(wr_lower_g2),
      .status_rd_in(rd_status_g2),
      .mask_out(mask_g2),
      .upper_out(upper_g2),
      .lower_out(lower_g2),
      .status_out(status_g2)
   );

   // read data shows the value held before the clear that the same read causes
   always_comb begin
      rdata_nxt = asi_pkg::UNMAPPED_READ;
      if (hit(reg_addr_in, asi_pkg::OFF_STATUS_G1)) begin
         rdata_nxt = status_g1;
      end else if (hit(reg_addr_in, asi_pkg::OFF_STATUS_G2)) begin
         rdata_nxt = widen2(status_g2);
      end else if (hit(reg_addr_in, asi_pkg::OFF_MASK_G1)) begin
         rdata_nxt = mask_g1;
      end else if (hit(reg_addr_in, asi_pkg::OFF_MODE_G1_UPPER)) begin
         rdata_nxt = upper_g1;
      end else if (hit(reg_addr_in, asi_pkg::OFF_MODE_G1_LOWER)) begin
         rdata_nxt = lower_g1;
      end else if (hit(reg_addr_in, asi_pkg::OFF_MASK_G2)) begin
         rdata_nxt = widen2(mask_g2);
      end else if (hit(reg_addr_in, asi_pkg::OFF_MODE_G2_UPPER)) begin
         rdata_nxt = widen2(upper_g2);
      end else if (hit(reg_addr_in, asi_pkg::OFF_MODE_G2_LOWER)) begin
         rdata_nxt = widen2(lower_g2);
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_r <= asi_pkg::RST_REG;
      end else if (reg_rd_in) begin
         rdata_r <= rdata_nxt;
      end
   end

   // rvalid stands for exactly the cycle after the read strobe
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd_in;
      end
   end

   // the pin ORs both groups
   always_comb begin
      irq_nxt = (|status_g1) | (|status_g2);
   end

   // status bits are already masked, so the pin follows them one cycle later;
   // the extra flop keeps the pin glitch-free at the cost of a cycle of latency
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   assign reg_rdata_out = rdata_r;
   assign reg_rvalid_out = rvalid_r;
   assign irq_out = irq_r;
endmodule
`default_nettype wire

// [asi_pkg.sv]
// constants for the audio converter interrupt status, mask and trigger-mode logic
// assumes a byte-wide register port driven by the control-port front end on clk_in
package asi_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int G1_W = 8;
   localparam int G2_W = 6;

   localparam logic [ADDR_W-1:0] OFF_STATUS_G1 = 7'h07;
   localparam logic [ADDR_W-1:0] OFF_STATUS_G2 = 7'h08;
   localparam logic [ADDR_W-1:0] OFF_MASK_G1 = 7'h09;
   localparam logic [ADDR_W-1:0] OFF_MODE_G1_UPPER = 7'h0A;
   localparam logic [ADDR_W-1:0] OFF_MODE_G1_LOWER = 7'h0B;
   localparam logic [ADDR_W-1:0] OFF_MASK_G2 = 7'h0C;
   localparam logic [ADDR_W-1:0] OFF_MODE_G2_UPPER = 7'h0D;
   localparam logic [ADDR_W-1:0] OFF_MODE_G2_LOWER = 7'h0E;

   localparam logic [DATA_W-1:0] RST_REG = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

   // mode code = {upper bit, lower bit}
   localparam logic [1:0] MODE_RISE = 2'h0;
   localparam logic [1:0] MODE_FALL = 2'h1;
   localparam logic [1:0] MODE_LEVEL = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;

   // first-group bit positions
   localparam int BIT_TIMING_SLIP = 7;
   localparam int BIT_OUTPUT_SLIP = 6;
   localparam int BIT_RATE_RATIO = 5;
   localparam int BIT_LEFT_OVR = 4;
   localparam int BIT_RIGHT_OVR = 3;
   localparam int BIT_CSTAT_DE = 2;
   localparam int BIT_CSTAT_EF = 1;
   localparam int BIT_RX_FAULT = 0;

   // second-group bit positions
   localparam int BIT_CONV_OVF = 5;
   localparam int BIT_CONV_TRACK = 4;
   localparam int BIT_USER_DE = 3;
   localparam int BIT_USER_EF = 2;
   localparam int BIT_SUBCODE_Q = 1;
   localparam int BIT_USER_OVW = 0;
endpackage

// [asi_event_group.sv]
// one group of interrupt events: mask, two mode registers, trigger detect, sticky status
// assumes sources are synchronous to clk_in and strobes are single-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module asi_event_group #(
   parameter int W = 8
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [W-1:0] src_in,
   input wire logic [W-1:0] wdata_in,
   input wire logic mask_wr_in,
   input wire logic upper_wr_in,
   input wire logic lower_wr_in,
   input wire logic status_rd_in,
   output logic [W-1:0] mask_out,
   output logic [W-1:0] upper_out,
   output logic [W-1:0] lower_out,
   output logic [W-1:0] status_out
);
   logic [W-1:0] mask_r;
   logic [W-1:0] upper_r;
   logic [W-1:0] lower_r;
   logic [W-1:0] status_r;
   logic [W-1:0] status_nxt;
   logic [W-1:0] src_q_r;
   logic [W-1:0] trig;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mask_r <= asi_pkg::RST_REG[W-1:0];
      end else if (mask_wr_in) begin
         mask_r <= wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         upper_r <= asi_pkg::RST_REG[W-1:0];
         lower_r <= asi_pkg::RST_REG[W-1:0];
      end else begin
         if (upper_wr_in) begin
            upper_r <= wdata_in;
         end
         if (lower_wr_in) begin
            lower_r <= wdata_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         src_q_r <= '0;
      end else begin
         src_q_r <= src_in;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic [1:0] code;
         assign code = {upper_r[i], lower_r[i]};
         always_comb begin
            case (code)
               asi_pkg::MODE_RISE: trig[i] = src_in[i] & ~src_q_r[i];
               asi_pkg::MODE_FALL: trig[i] = ~src_in[i] & src_q_r[i];
               asi_pkg::MODE_LEVEL: trig[i] = src_in[i];
               default: trig[i] = 1'b0; // reserved code never fires
            endcase
         end
      end
   endgenerate

   // a read clears, but a trigger in the same cycle wins; level mode with the
   // source still true re-triggers and so stays set; masked bits drop to zero
   always_comb begin
      status_nxt = status_r;
      if (status_rd_in) begin
         status_nxt = '0;
      end
      status_nxt = (status_nxt | trig) & mask_r;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         status_r <= asi_pkg::RST_REG[W-1:0];
      end else begin
         status_r <= status_nxt;
      end
   end

   assign mask_out = mask_r;
   assign upper_out = upper_r;
   assign lower_out = lower_r;
   assign status_out = status_r;
endmodule
`default_nettype wire

// [asi_interrupt_properties.sv]
// port-level assertions for the interrupt status, mask and mode logic
// assumes one clock domain and reads/writes never share a cycle
`timescale 1ns/1ps
`default_nettype none
module asi_interrupt_properties (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [asi_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [asi_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic [asi_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic irq_out
);
   logic [7:0] m1_r;
   logic [5:0] m2_r;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   // shadow copies of the masks, so reads and the pin can be judged against them
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         m1_r <= 8'h00;
         m2_r <= 6'h00;
      end else if (reg_wr_in && reg_addr_in == asi_pkg::OFF_MASK_G1) begin
         m1_r <= reg_wdata_in;
      end else if (reg_wr_in && reg_addr_in == asi_pkg::OFF_MASK_G2) begin
         m2_r <= reg_wdata_in[5:0];
      end
   end
   a_rvalid_follows_rd: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read answer missing");
   a_rvalid_only_rd: assert property (reg_rvalid_out |-> $past(reg_rd_in))
      else $error("read answer without read");
   a_rdata_holds: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
      else $error("read data moved without read");
   a_g2_status_top: assert property (reg_rvalid_out &&
      $past(reg_addr_in) == asi_pkg::OFF_STATUS_G2 |-> reg_rdata_out[7:6] == 2'h0)
      else $error("group two status top bits set");
   a_mask1_readback: assert property (reg_rvalid_out &&
      $past(reg_addr_in) == asi_pkg::OFF_MASK_G1 |-> reg_rdata_out == m1_r)
      else $error("group one mask readback wrong");
   a_mask2_readback: assert property (reg_rvalid_out &&
      $past(reg_addr_in) == asi_pkg::OFF_MASK_G2 |-> reg_rdata_out == {2'h0, m2_r})
      else $error("group two mask readback wrong");
   a_g2_mode_top: assert property (reg_rvalid_out &&
      ($past(reg_addr_in) == asi_pkg::OFF_MODE_G2_UPPER ||
      $past(reg_addr_in) == asi_pkg::OFF_MODE_G2_LOWER) |-> reg_rdata_out[7:6] == 2'h0)
      else $error("group two mode top bits set");
   // a mask cleared just before the read may still show for one cycle
   a_status_masked: assert property (reg_rvalid_out &&
      $past(reg_addr_in) == asi_pkg::OFF_STATUS_G1 |->
      (reg_rdata_out & ~(m1_r | $past(m1_r, 2))) == 8'h00)
      else $error("masked status bit read as set");
   a_masked_pin_quiet: assert property ((m1_r == 8'h00 && m2_r == 6'h00)[*3]
      |-> !irq_out)
      else $error("interrupt with all events masked");
   c_irq_rise: cover property ($rose(irq_out));
   c_status_set: cover property (reg_rvalid_out && reg_rdata_out != 8'h00);
   c_mask2_write: cover property (reg_wr_in && reg_addr_in == asi_pkg::OFF_MASK_G2);
endmodule
bind asi_interrupt_logic asi_interrupt_properties u_props (.clk_in(clk_in),
   .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .reg_rvalid_out(reg_rvalid_out), .irq_out(irq_out));
`default_nettype wire

// [asi_host_model.sv]
// host side of the register port: one-cycle read and write strobes
// assumes the bench calls its tasks; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module asi_host_model (
   input wire logic clk_in,
   output logic [asi_pkg::ADDR_W-1:0] addr_out,
   output logic wr_out,
   output logic rd_out,
   output logic [asi_pkg::DATA_W-1:0] wdata_out,
   input wire logic [asi_pkg::DATA_W-1:0] rdata_in,
   input wire logic rvalid_in
);
   initial begin
      addr_out = 7'h7F;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 8'h00;
   end
   // released lines show the inverse so a late sample cannot pass by luck
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge clk_in);
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
   task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge clk_in);
      rd_out = 1'b0;
      addr_out = ~a;
      d = rvalid_in ? rdata_in : 8'hXX;
   endtask
endmodule
`default_nettype wire

// [asi_interrupt_logic_bench.sv]
// self-checking bench for the interrupt status, mask and mode logic
// assumes the host model issues all register traffic
`timescale 1ns/1ps
`default_nettype none
module asi_interrupt_logic_bench;
   logic clk_in, resetn_in, wr, rd, rvalid, irq;
   logic [6:0] addr, a;
   logic [7:0] wdata, rdata, d, s1;
   logic [5:0] s2;
   logic [16:0] lfsr_r = 17'h15B28;
   logic [6:0] rmap [10] = '{7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E,
      7'h00, 7'h7F};
   int errors = 0;
   int num_checks = 0;
   asi_host_model u_host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd),
      .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
   asi_interrupt_logic u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .timing_slip_event_in(s1[7]), .output_slip_event_in(s1[6]),
      .rate_ratio_exceeded_in(s1[5]), .left_overrange_in(s1[4]), .right_overrange_in(s1[3]),
      .cstat_d_to_e_transfer_in(s1[2]), .cstat_e_to_f_transfer_in(s1[1]),
      .receiver_fault_event_in(s1[0]), .converter_buffer_overflow_in(s2[5]),
      .converter_tracking_event_in(s2[4]), .user_d_to_e_transfer_in(s2[3]),
      .user_e_to_f_transfer_in(s2[2]), .subcode_q_ready_in(s2[1]),
      .user_fifo_overwrite_in(s2[0]), .irq_out(irq));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   // group two keeps only six bits
   function automatic logic [7:0] exp_rb(input logic [6:0] ad, input logic [7:0] v);
      return (ad >= 7'h0C) ? {2'h0, v[5:0]} : v;
   endfunction
   // m: 0 rise, 1 fall, 2 level, 3 reserved, 4 masked; p: read phase
   function automatic logic ev_exp(input int m, input int p);
      return (m == 2) || (p == 1 && m == 0) || (p == 3 && m == 1);
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic set_src(input int g, input logic [7:0] v);
      if (g) s2 = v[5:0];
      else s1 = v;
   endtask
   task automatic ev_test(input int g, input int b, input int m);
      logic [7:0] bv;
      logic [6:0] base, st;
      bv = 8'h01 << b;
      base = g ? 7'h0C : 7'h09;
      st = g ? 7'h08 : 7'h07;
      u_host.wr_reg(g ? 7'h09 : 7'h0C, 8'h00);
      u_host.wr_reg(base, m == 4 ? 8'h00 : bv);
      u_host.wr_reg(base + 7'h01, m[1] ? bv : 8'h00);
      u_host.wr_reg(base + 7'h02, m[0] ? bv : 8'h00);
      u_host.rd_reg(st, d);
      @(negedge clk_in);
      set_src(g, bv);
      repeat (3) @(negedge clk_in);
      chk({7'h00, irq}, {7'h00, ev_exp(m, 1)});
      u_host.rd_reg(st, d);
      chk(d, ev_exp(m, 1) ? bv : 8'h00);
      u_host.rd_reg(st, d);
      chk(d, ev_exp(m, 2) ? bv : 8'h00);
      set_src(g, 8'h00);
      repeat (3) @(negedge clk_in);
      u_host.rd_reg(st, d);
      chk(d, ev_exp(m, 3) ? bv : 8'h00);
      @(negedge clk_in);
      chk({7'h00, irq}, 8'h00);
   endtask
   initial begin
      #400000;
      errors++;
      finish_test;
   end
   initial begin
      resetn_in = 1'b0;
      s1 = 8'h00;
      s2 = 6'h00;
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      resetn_in = 1'b1;
      foreach (rmap[i]) begin
         u_host.rd_reg(rmap[i], d);
         chk(d, 8'h00);
      end
      repeat (24) begin
         lfsr_r = lfsr_next(lfsr_r);
         a = 7'h09 + 7'(lfsr_r[2:0] % 3'h6);
         u_host.wr_reg(a, lfsr_r[15:8]);
         u_host.rd_reg(a, d);
         chk(d, exp_rb(a, lfsr_r[15:8]));
      end
      u_host.wr_reg(7'h08, 8'hFF);
      u_host.rd_reg(7'h08, d);
      chk(d, 8'h00);
      for (int g = 0; g < 2; g++) begin
         for (int b = 0; b < (g ? 6 : 8); b++) begin
            for (int m = 0; m < 5; m++) begin
               ev_test(g, b, m);
            end
         end
      end
      finish_test;
   end
endmodule
`default_nettype wire
